// ==== aismr_pkg.sv ====
// Package of constants and types for the identity, status and input-select register bank.
//
// Overview of operation
// - The identity register is read-only: bits 2:0 hold the model code, 7:3 are reserved.
// - Every power-on reset sets status bit 7, which stays set until the host writes a 0 to it.
// - Status bit 6 reads 1 while start-up is still pending and 0 once the device can talk.
// - Status bits 5 and 4 flag the positive amplifier output near the upper and lower rail.
// - Status bits 3 and 2 flag the negative amplifier output near the upper and lower rail.
// - Status bit 1 flags a differential reference below one third of the analog supply span.
// - Status bit 0 flags a reference below the low absolute threshold, i.e. a missing one.
// - The four rail flags are live only while the rail monitor enable is set.
// - The two reference flags are live only while reference monitoring is enabled.
// - The status register sits at address 01h and resets to 80h.
// - Input select at 02h is read/write; positive select 7:4 resets to 0, negative 3:0 to 1.
// - Codes 0 to 11 select analog inputs 0 to 11, code 12 the common input; others are reserved.
// - The register read command reads and the register write command writes the registers.
package aismr_pkg;

    localparam logic [4:0] AISMR_ADDR_IDENTITY = 5'h00;
    localparam logic [4:0] AISMR_ADDR_CONDITION = 5'h01;
    localparam logic [4:0] AISMR_ADDR_INSEL = 5'h02;

    localparam logic [7:0] AISMR_CONDITION_RST = 8'h80;
    localparam logic [7:0] AISMR_INSEL_RST = 8'h01;

    localparam int AISMR_POR_BIT = 7;
    localparam int AISMR_POS_SEL_LSB = 4;
    localparam int AISMR_NEG_SEL_LSB = 0;

    localparam logic [2:0] AISMR_OP_READ = 3'h1;
    localparam logic [2:0] AISMR_OP_WRITE = 3'h2;

    localparam int AISMR_NUM_INPUTS = 13;
    localparam logic [3:0] AISMR_SEL_COMMON = 4'hc;
    localparam logic [1:0] AISMR_REF_MON_OFF = 2'h0;

    typedef enum logic [4:0] {
        AISMR_CMD_IDLE = 5'b00001,
        AISMR_CMD_RCOUNT = 5'b00010,
        AISMR_CMD_WCOUNT = 5'b00100,
        AISMR_CMD_READ = 5'b01000,
        AISMR_CMD_WRITE = 5'b10000
    } aismr_cmd_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } aismr_spi_in_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } aismr_byte_t;

    typedef struct packed {
        logic pos_high;
        logic pos_low;
        logic neg_high;
        logic neg_low;
        logic ref_third;
        logic ref_missing;
    } aismr_mon_t;

endpackage

// ==== aismr_spi_shift.sv ====
// Serial shifter that turns the sampled serial pins into bytes and shifts reply bytes out.
module aismr_spi_shift
    import aismr_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input aismr_spi_in_t spi_in,
    input wire logic tx_load,
    input wire logic [7:0] tx_byte,
    output aismr_byte_t rx,
    output logic dout,
    output logic dout_oe
);

    typedef struct packed {
        logic sclk_prev;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sr;
        logic [7:0] tx_sr;
        aismr_byte_t rx;
        logic dout;
        logic dout_oe;
    } aismr_shift_state_t;

    aismr_shift_state_t s;
    aismr_shift_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////////

    // Input bits are taken on the falling edge, reply bits change on the rising edge.
    always_comb begin
        next_s = s;
        next_s.rx.valid = 1'b0;
        next_s.sclk_prev = spi_in.sclk;
        next_s.dout_oe = ~spi_in.cs_n;
        if (spi_in.cs_n) begin
            next_s.bit_cnt = 3'h0;
            next_s.tx_sr = 8'h00;
            next_s.dout = 1'b0;
        end else begin
            if (spi_in.sclk && !s.sclk_prev) begin
                next_s.dout = s.tx_sr[7];
                next_s.tx_sr = {s.tx_sr[6:0], 1'b0};
            end
            if (!spi_in.sclk && s.sclk_prev) begin
                next_s.rx_sr = {s.rx_sr[6:0], spi_in.din};
                next_s.bit_cnt = s.bit_cnt + 3'h1;
                if (s.bit_cnt == 3'h7) begin
                    next_s.rx.valid = 1'b1;
                    next_s.rx.data = {s.rx_sr[6:0], spi_in.din};
                end
            end
            // A load arrives while the clock is low, so it never meets a shift.
            if (tx_load) begin
                next_s.tx_sr = tx_byte;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rx = s.rx;
    assign dout = s.dout;
    assign dout_oe = s.dout_oe;

endmodule

// ==== aismr_regs.sv ====
// Identity, condition-flag and input-select registers behind the serial register commands.
module aismr_regs
    import aismr_pkg::*;
#(
    // Arbitrary model code; the real part value is set at integration.
    parameter logic [2:0] MODEL_IDENTIFIER = 3'h2,
    // Arbitrary content of the reserved identity bits.
    parameter logic [4:0] IDENTITY_RESERVED = 5'h00
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input aismr_spi_in_t spi_in,
    output logic dout,
    output logic dout_oe,
    input wire logic startup_pending,
    input aismr_mon_t monitor_cmp,
    input wire logic rail_monitor_enable,
    input wire logic [1:0] reference_monitor_enable,
    output logic [3:0] positive_input_select,
    output logic [3:0] negative_input_select,
    output logic [AISMR_NUM_INPUTS-1:0] positive_input_onehot,
    output logic [AISMR_NUM_INPUTS-1:0] negative_input_onehot,
    output logic power_on_flag
);

    typedef struct packed {
        aismr_cmd_t cmd;
        logic [4:0] addr;
        logic [5:0] remaining;
        logic power_on_flag;
        logic not_ready;
        aismr_mon_t flags;
        logic [7:0] insel;
        logic [AISMR_NUM_INPUTS-1:0] pos_onehot;
        logic [AISMR_NUM_INPUTS-1:0] neg_onehot;
        logic tx_load;
        logic [7:0] tx_byte;
    } aismr_regs_state_t;

    aismr_regs_state_t s;
    aismr_regs_state_t next_s;
    aismr_byte_t rx;
    logic [AISMR_NUM_INPUTS-1:0] pos_dec;
    logic [AISMR_NUM_INPUTS-1:0] neg_dec;

    ////////////////////////////////////////////////////////////////////////////////

    aismr_spi_shift u_shift (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .spi_in(spi_in),
        .tx_load(s.tx_load),
        .tx_byte(s.tx_byte),
        .rx(rx),
        .dout(dout),
        .dout_oe(dout_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // Reserved select codes decode to no input at all.
    generate
        for (genvar i = 0; i < AISMR_NUM_INPUTS; i++) begin : g_sel
            assign pos_dec[i] = (s.insel[AISMR_POS_SEL_LSB +: 4] == 4'(i));
            assign neg_dec[i] = (s.insel[AISMR_NEG_SEL_LSB +: 4] == 4'(i));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] reg_value(input aismr_regs_state_t st, input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            AISMR_ADDR_IDENTITY: v = {IDENTITY_RESERVED, MODEL_IDENTIFIER};
            AISMR_ADDR_CONDITION: v = {st.power_on_flag, st.not_ready, st.flags};
            AISMR_ADDR_INSEL: v = st.insel;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;
        next_s.tx_load = 1'b0;
        next_s.pos_onehot = pos_dec;
        next_s.neg_onehot = neg_dec;
        next_s.not_ready = startup_pending;
        // Gating here rather than at read time keeps stale comparator levels out of the flags.
        if (rail_monitor_enable) begin
            next_s.flags.pos_high = monitor_cmp.pos_high;
            next_s.flags.pos_low = monitor_cmp.pos_low;
            next_s.flags.neg_high = monitor_cmp.neg_high;
            next_s.flags.neg_low = monitor_cmp.neg_low;
        end else begin
            next_s.flags.pos_high = 1'b0;
            next_s.flags.pos_low = 1'b0;
            next_s.flags.neg_high = 1'b0;
            next_s.flags.neg_low = 1'b0;
        end
        if (reference_monitor_enable != AISMR_REF_MON_OFF) begin
            next_s.flags.ref_third = monitor_cmp.ref_third;
            next_s.flags.ref_missing = monitor_cmp.ref_missing;
        end else begin
            next_s.flags.ref_third = 1'b0;
            next_s.flags.ref_missing = 1'b0;
        end

        // Raising chip select abandons any command half way through.
        if (spi_in.cs_n) begin
            next_s.cmd = AISMR_CMD_IDLE;
        end else if (rx.valid) begin
            case (s.cmd)
                AISMR_CMD_IDLE: begin
                    next_s.addr = rx.data[4:0];
                    if (rx.data[7:5] == AISMR_OP_READ) begin
                        next_s.cmd = AISMR_CMD_RCOUNT;
                    end else if (rx.data[7:5] == AISMR_OP_WRITE) begin
                        next_s.cmd = AISMR_CMD_WCOUNT;
                    end
                end
                AISMR_CMD_RCOUNT: begin
                    next_s.remaining = 6'(rx.data[4:0]) + 6'h01;
                    next_s.cmd = AISMR_CMD_READ;
                    next_s.tx_load = 1'b1;
                    next_s.tx_byte = reg_value(s, s.addr);
                    next_s.addr = s.addr + 5'h01;
                end
                AISMR_CMD_WCOUNT: begin
                    next_s.remaining = 6'(rx.data[4:0]) + 6'h01;
                    next_s.cmd = AISMR_CMD_WRITE;
                end
                AISMR_CMD_READ: begin
                    next_s.remaining = s.remaining - 6'h01;
                    if (s.remaining == 6'h01) begin
                        next_s.cmd = AISMR_CMD_IDLE;
                    end else begin
                        next_s.tx_load = 1'b1;
                        next_s.tx_byte = reg_value(s, s.addr);
                        next_s.addr = s.addr + 5'h01;
                    end
                end
                AISMR_CMD_WRITE: begin
                    next_s.remaining = s.remaining - 6'h01;
                    next_s.addr = s.addr + 5'h01;
                    if (s.remaining == 6'h01) begin
                        next_s.cmd = AISMR_CMD_IDLE;
                    end
                    // Identity writes fall through to the default and change nothing.
                    case (s.addr)
                        AISMR_ADDR_CONDITION: begin
                            if (!rx.data[AISMR_POR_BIT]) begin
                                next_s.power_on_flag = 1'b0;
                            end
                        end
                        AISMR_ADDR_INSEL: next_s.insel = rx.data;
                        default: next_s.insel = s.insel;
                    endcase
                end
                default: next_s.cmd = AISMR_CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.cmd <= AISMR_CMD_IDLE;
            s.power_on_flag <= AISMR_CONDITION_RST[AISMR_POR_BIT];
            s.insel <= AISMR_INSEL_RST;
        end else begin
            s <= next_s;
        end
    end

    assign positive_input_select = s.insel[AISMR_POS_SEL_LSB +: 4];
    assign negative_input_select = s.insel[AISMR_NEG_SEL_LSB +: 4];
    assign positive_input_onehot = s.pos_onehot;
    assign negative_input_onehot = s.neg_onehot;
    assign power_on_flag = s.power_on_flag;

endmodule

// ==== aismr_regs_asserts.sv ====
// Port-level checks of the identity, status and input-select register bank.
module aismr_regs_asserts
    import aismr_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input aismr_spi_in_t spi_in,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic startup_pending,
    input aismr_mon_t monitor_cmp,
    input wire logic rail_monitor_enable,
    input wire logic [1:0] reference_monitor_enable,
    input wire logic [3:0] positive_input_select,
    input wire logic [3:0] negative_input_select,
    input wire logic [AISMR_NUM_INPUTS-1:0] positive_input_onehot,
    input wire logic [AISMR_NUM_INPUTS-1:0] negative_input_onehot,
    input wire logic power_on_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Codes 13 to 15 are reserved and must select nothing.
    function automatic logic [12:0] hot(input logic [3:0] c);
        return (c < 4'hd) ? 13'h0001 << c : 13'h0000;
    endfunction
    chk_rst_por_set: assert property ($past(sys_rst) |-> power_on_flag)
        else $error("power-on flag clear after reset");
    chk_rst_sel_val: assert property (
        $past(sys_rst) |-> {positive_input_select, negative_input_select} == AISMR_INSEL_RST)
        else $error("input select not at reset value");
    chk_por_no_set: assert property (
        !$past(sys_rst) && !$past(power_on_flag) |-> !power_on_flag)
        else $error("power-on flag set without reset");
    chk_por_clear_cmd: assert property ($fell(power_on_flag) |-> !$past(spi_in.cs_n, 2))
        else $error("power-on flag cleared outside a frame");
    chk_pos_hot: assert property (
        !$past(sys_rst) |-> positive_input_onehot == hot($past(positive_input_select)))
        else $error("positive one-hot wrong");
    chk_neg_hot: assert property (
        !$past(sys_rst) |-> negative_input_onehot == hot($past(negative_input_select)))
        else $error("negative one-hot wrong");
    chk_oe_follow_cs: assert property (!$past(sys_rst) |-> dout_oe == !$past(spi_in.cs_n))
        else $error("output enable does not follow select");
    chk_dout_idle_low: assert property ($past(spi_in.cs_n) |-> !dout)
        else $error("data out driven while deselected");
    chk_sel_only_cmd: assert property (
        !$past(sys_rst) && $changed({positive_input_select, negative_input_select})
        |-> !$past(spi_in.cs_n, 2))
        else $error("input select changed outside a frame");
    cover property ($fell(power_on_flag));
    cover property (positive_input_onehot[12]);
    cover property (dout_oe && dout);
endmodule
bind aismr_regs aismr_regs_asserts chk_u (.*);

// ==== aismr_host.sv ====
// Host model issuing serial register commands.
module aismr_host
    import aismr_pkg::*;
(
    input wire logic core_clk,
    input wire logic dout,
    input wire logic dout_oe,
    output aismr_spi_in_t spi_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial spi_in = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // Four core clocks per serial phase so the device sees every edge.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_in.din = tx[i];
            spi_in.sclk = 1'b1;
            tick(4);
            // A released line reads as the inverse of its last level, so an undriven bit shows.
            rx[i] = dout_oe ? dout : ~dout;
            spi_in.sclk = 1'b0;
            tick(4);
        end
    endtask
    // A deselected data line is flipped so no stale bit is mistaken for data.
    task automatic sel(input logic on);
        spi_in.cs_n = !on;
        if (!on)
            spi_in.din = !spi_in.din;
        tick(4);
    endtask
endmodule

// ==== aismr_regs_test.sv ====
// Self-checking testbench of the register bank.
module aismr_regs_test
    import aismr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic startup_pending;
    aismr_mon_t monitor_cmp;
    logic rail_monitor_enable;
    logic [1:0] reference_monitor_enable;
    aismr_spi_in_t spi_in;
    logic dout, dout_oe, power_on_flag;
    logic [3:0] pos_sel, neg_sel;
    logic [12:0] pos_hot, neg_hot;
    logic [7:0] v;
    int errors = 0;
    int cmp_count = 0;
    always #12.5 core_clk = ~core_clk;
    aismr_host host_u (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe), .spi_in(spi_in));
    aismr_regs dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .spi_in(spi_in), .dout(dout),
        .dout_oe(dout_oe), .startup_pending(startup_pending), .monitor_cmp(monitor_cmp),
        .rail_monitor_enable(rail_monitor_enable),
        .reference_monitor_enable(reference_monitor_enable),
        .positive_input_select(pos_sel), .negative_input_select(neg_sel),
        .positive_input_onehot(pos_hot), .negative_input_onehot(neg_hot),
        .power_on_flag(power_on_flag));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmd(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d);
        host_u.sel(1'b1);
        host_u.xfer({op, a}, v);
        host_u.xfer(8'h00, v);
        host_u.xfer(d, v);
        host_u.sel(1'b0);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        cmd(AISMR_OP_READ, a, 8'h00);
        check(v, exp);
    endtask
    task automatic t_reset();
        check(power_on_flag, 1'b1);
        check({pos_sel, neg_sel}, AISMR_INSEL_RST);
        rd(AISMR_ADDR_CONDITION, AISMR_CONDITION_RST);
        rd(AISMR_ADDR_INSEL, AISMR_INSEL_RST);
        // Reserved identity bits may vary, so only the model code is compared.
        cmd(AISMR_OP_READ, AISMR_ADDR_IDENTITY, 8'h00);
        check(v[2:0], 3'h2);
    endtask
    task automatic t_guard();
        cmd(AISMR_OP_WRITE, AISMR_ADDR_IDENTITY, 8'hff);
        cmd(AISMR_OP_READ, AISMR_ADDR_IDENTITY, 8'h00);
        check(v[2:0], 3'h2);
        cmd(AISMR_OP_WRITE, AISMR_ADDR_CONDITION, 8'hff);
        rd(AISMR_ADDR_CONDITION, 8'h80);
        cmd(AISMR_OP_WRITE, AISMR_ADDR_CONDITION, 8'h7f);
        rd(AISMR_ADDR_CONDITION, 8'h00);
        check(power_on_flag, 1'b0);
        cmd(AISMR_OP_WRITE, 5'h03, 8'hff);
        rd(5'h03, 8'h00);
        cmd(3'h6, AISMR_ADDR_INSEL, 8'h77);
        rd(AISMR_ADDR_INSEL, AISMR_INSEL_RST);
    endtask
    task automatic t_flags();
        startup_pending = 1'b1;
        rd(AISMR_ADDR_CONDITION, 8'h40);
        startup_pending = 1'b0;
        for (int i = 0; i < 6; i++) begin
            monitor_cmp = 6'h20 >> i;
            rail_monitor_enable = (i >= 4);
            reference_monitor_enable = (i < 4) ? 2'(i % 3 + 1) : 2'h0;
            rd(AISMR_ADDR_CONDITION, 8'h00);
            rail_monitor_enable = 1'b1;
            reference_monitor_enable = 2'(i % 3 + 1);
            rd(AISMR_ADDR_CONDITION, 8'h20 >> i);
        end
        monitor_cmp = '0;
    endtask
    task automatic t_mux();
        logic [7:0] m;
        for (int c = 0; c < 16; c++) begin
            m = {4'(c), ~4'(c)};
            cmd(AISMR_OP_WRITE, AISMR_ADDR_INSEL, m);
            check({pos_sel, neg_sel}, m);
            check(pos_hot, (c < 13) ? 13'h0001 << c : 13'h0000);
            check(neg_hot, (15 - c < 13) ? 13'h0001 << (15 - c) : 13'h0000);
            rd(AISMR_ADDR_INSEL, m);
        end
    endtask
    // Two-byte write and three-byte read back to back in one frame, so the address steps.
    task automatic t_burst();
        logic [7:0] b;
        host_u.sel(1'b1);
        host_u.xfer({AISMR_OP_WRITE, AISMR_ADDR_CONDITION}, b);
        host_u.xfer(8'h01, b);
        host_u.xfer(8'h7f, b);
        host_u.xfer(8'h5a, b);
        host_u.xfer({AISMR_OP_READ, AISMR_ADDR_IDENTITY}, b);
        host_u.xfer(8'h02, b);
        host_u.xfer(8'h00, b);
        check(b[2:0], 3'h2);
        host_u.xfer(8'h00, b);
        check(b, 8'h00);
        host_u.xfer(8'h00, b);
        check(b, 8'h5a);
        host_u.sel(1'b0);
        check({pos_sel, neg_sel}, 8'h5a);
    endtask
    initial begin
        startup_pending = 1'b0;
        monitor_cmp = '0;
        rail_monitor_enable = 1'b0;
        reference_monitor_enable = 2'h0;
        host_u.tick(8);
        sys_rst = 1'b0;
        host_u.tick(2);
        t_reset();
        t_guard();
        t_flags();
        t_mux();
        t_burst();
        sys_rst = 1'b1;
        host_u.tick(8);
        sys_rst = 1'b0;
        host_u.tick(2);
        t_reset();
        test_done();
    end
    // About 13000 cycles are needed; the limit of 40000 leaves ample margin.
    initial begin
        #1000000;
        errors++;
        test_done();
    end
endmodule
